// ---- core/uus_core.sv ----
`timescale 1ns/1ns
// Behaviour
// - Config writes wait while operation is enabled, then apply once it is left.
// - Position word: unit code in 23:16, exponent in 31:24, low half zero.
// - Speed word: time 15:8, position 23:16, exponent 31:24, low byte reserved.
// - Length and dimensionless codes use both gear ratio and feed constant.
// - Angular and revolution codes use the gear ratio but not the feed.
// - Encoder increments: no gear or feed; open loop turn is pole pairs times 65536.
// - Steps: no gear or feed; turn is pole pairs times four or six.
// - Electrical poles: no gear or feed; one unit is a turn over pole pairs.
// - Time codes decode to second, minute, hour, day and 365.25-day year.
// - Exponent byte is a signed power of ten between minus six and six.
// - Resolution is encoder increments divided by motor revolutions.
// - Gear ratio is motor-shaft turns divided by driving-shaft turns.
// - Feed constant is feed over shaft turns, used only for length and dimensionless units.
// - Speed unit carries an extra numerator over denominator factor.
// - Acceleration is speed unit per second times its own ratio.
// - Jerk is acceleration unit per second times its own ratio.
// - Velocity mode uses revolutions per minute scaled by its own factor in place of the speed factor.
module uus_core #(
   parameter int NW = 128
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [uus_pkg::UUS_AW-1:0] paddr,
   input wire logic [uus_pkg::UUS_DW-1:0] pwdata,
   input wire logic [uus_pkg::UUS_SW-1:0] pstrb,
   output logic [uus_pkg::UUS_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic op_enabled,
   input wire logic velocity_mode,
   output logic cfg_pending,
   output logic conv_busy,
   output logic conv_done
);
   import uus_pkg::*;

   localparam int MW = NW + UUS_DW;
   localparam int NTERM = 9;
   localparam int T_IPR = 0;
   localparam int T_GEAR = 1;
   localparam int T_FEED = 2;
   localparam int T_TURN = 3;
   localparam int T_POW = 4;
   localparam int T_SPD = 5;
   localparam int T_TIME = 6;
   localparam int T_ACC = 7;
   localparam int T_JERK = 8;

   typedef enum logic [1:0] {S_IDLE, S_LOAD, S_RUN} uus_state_t;

   // Reset contents of each configuration word
   function automatic logic [UUS_DW-1:0] cfg_reset(input int i);
      case (i)
         IDX_POS_UNIT: return POS_UNIT_RST;
         IDX_SPD_UNIT: return SPD_UNIT_RST;
         IDX_MOTOR_CFG: return ZERO;
         default: return ONE;
      endcase
   endfunction : cfg_reset

   // Writable bits; reserved fields always read back as zero
   function automatic logic [UUS_DW-1:0] cfg_mask(input int i);
      case (i)
         IDX_POS_UNIT: return POS_WORD_MASK;
         IDX_SPD_UNIT: return SPD_WORD_MASK;
         IDX_MOTOR_CFG: return MCFG_MASK;
         default: return ALL_MASK;
      endcase
   endfunction : cfg_mask

   // Byte-lane merge under the write strobes
   function automatic logic [UUS_DW-1:0] merge(input logic [UUS_DW-1:0] old,
                                               input logic [UUS_DW-1:0] nw,
                                               input logic [UUS_SW-1:0] strb);
      logic [UUS_DW-1:0] r;
      r = old;
      for (int b = 0; b < UUS_SW; b++) begin
         if (strb[b]) begin
            r[b*BYTE_W +: BYTE_W] = nw[b*BYTE_W +: BYTE_W];
         end
      end
      return r;
   endfunction : merge

   int widx;
   logic setup_ph, access_ph, mapped, wr_en, start_req;
   uus_ctrl_t ctrl_w;

   // Zero wait states: read data is captured in the setup phase
   assign widx = int'(paddr[UUS_AW-1:ADDR_LSB]);
   assign setup_ph = psel & ~penable;
   assign access_ph = psel & penable;
   assign mapped = (widx <= IDX_LAST);
   assign wr_en = access_ph & pwrite & mapped;
   assign pready = 1'b1;
   assign pslverr = access_ph & ~mapped;
   assign ctrl_w = pwdata;
   assign start_req = wr_en && (widx == IDX_CONV_CTRL) && pstrb[0] && ctrl_w.start;

   logic [UUS_DW-1:0] pend_q [CFG_N];
   logic [UUS_DW-1:0] pend_d [CFG_N];
   logic [UUS_DW-1:0] act_q [CFG_N];
   logic [UUS_DW-1:0] act_d [CFG_N];
   logic dirty_q, dirty_d;

   // Software always writes the pending copy; the active copy follows only outside
   // operation enabled, so a moving axis never sees its scaling change underneath it
   always_comb begin
      dirty_d = dirty_q;
      for (int i = 0; i < CFG_N; i++) begin
         pend_d[i] = pend_q[i];
         if (wr_en && widx == i) begin
            pend_d[i] = merge(pend_q[i], pwdata, pstrb) & cfg_mask(i);
         end
         act_d[i] = op_enabled ? act_q[i] : pend_q[i];
      end
      if (!op_enabled) begin
         dirty_d = 1'b0;
      end
      if (wr_en && widx < CFG_N) begin
         dirty_d = 1'b1; // A write in the copy cycle keeps the flag set
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < CFG_N; i++) begin
            pend_q[i] <= cfg_reset(i);
            act_q[i] <= cfg_reset(i);
         end
         dirty_q <= 1'b0;
      end else begin
         for (int i = 0; i < CFG_N; i++) begin
            pend_q[i] <= pend_d[i];
            act_q[i] <= act_d[i];
         end
         dirty_q <= dirty_d;
      end
   end

   uus_unit_word_t pos_word, spd_word;
   uus_dec_t pos_dec, spd_dec, sel_dec;
   uus_mcfg_t mcfg;
   uus_kind_t kind_q, kind_d;

   // Velocity mode ignores the general speed word and runs in rev per minute
   assign pos_word = act_q[IDX_POS_UNIT];
   assign spd_word = velocity_mode ? VEL_MODE_WORD : act_q[IDX_SPD_UNIT];
   assign mcfg = act_q[IDX_MOTOR_CFG];

   uus_decode u_pos_dec (
      .word(pos_word),
      .time_en(1'b0),
      .dec(pos_dec)
   );

   uus_decode u_spd_dec (
      .word(spd_word),
      .time_en(1'b1),
      .dec(spd_dec)
   );

   logic [UUS_DW-1:0] nt [NTERM];
   logic [UUS_DW-1:0] dt [NTERM];
   logic [NW-1:0] num, den;

   // Motor increments per user unit as a product of ratio terms; overflow past NW is lost
   always_comb begin
      logic [UUS_DW-1:0] pp;
      pp = act_q[IDX_POLE_PAIRS];
      sel_dec = (kind_q == K_POS) ? pos_dec : spd_dec;
      for (int i = 0; i < NTERM; i++) begin
         nt[i] = ONE;
         dt[i] = ONE;
      end
      if (mcfg.open_loop) begin
         nt[T_IPR] = UUS_DW'(pp * OL_INC_PER_POLE);
      end else begin
         nt[T_IPR] = act_q[IDX_ENC_INC];
         dt[T_IPR] = act_q[IDX_MOTOR_REV];
      end
      if (sel_dec.gear) begin
         nt[T_GEAR] = act_q[IDX_GEAR_MOTOR];
         dt[T_GEAR] = act_q[IDX_GEAR_SHAFT];
      end
      if (sel_dec.feed) begin
         nt[T_FEED] = act_q[IDX_FEED_SHAFT];
         dt[T_FEED] = act_q[IDX_FEED];
      end
      case (sel_dec.cls)
         C_ANGLE: begin
            nt[T_TURN] = sel_dec.tn;
            dt[T_TURN] = sel_dec.td;
         end
         C_ENC: begin
            nt[T_IPR] = ONE;
            dt[T_IPR] = ONE;
         end
         C_STEP: dt[T_TURN] = UUS_DW'(pp * (mcfg.three_phase ? STEPS_3PH : STEPS_2PH));
         C_POLE: dt[T_TURN] = pp;
         default: dt[T_TURN] = ONE;
      endcase
      nt[T_POW] = sel_dec.pow_n;
      dt[T_POW] = sel_dec.pow_d;
      if (kind_q != K_POS) begin
         if (velocity_mode) begin
            nt[T_SPD] = act_q[IDX_VMS_NUM];
            dt[T_SPD] = act_q[IDX_VMS_DEN];
         end else begin
            nt[T_SPD] = act_q[IDX_VEL_NUM];
            dt[T_SPD] = act_q[IDX_VEL_DEN];
         end
         dt[T_TIME] = sel_dec.secs;
      end
      if (kind_q == K_ACC || kind_q == K_JERK) begin
         nt[T_ACC] = act_q[IDX_ACC_NUM];
         dt[T_ACC] = act_q[IDX_ACC_DEN];
      end
      if (kind_q == K_JERK) begin
         nt[T_JERK] = act_q[IDX_JERK_NUM];
         dt[T_JERK] = act_q[IDX_JERK_DEN];
      end
      num = NW'(1);
      den = NW'(1);
      for (int i = 0; i < NTERM; i++) begin
         num = NW'(num * nt[i]);
         den = NW'(den * dt[i]);
      end
   end

   uus_state_t state_q, state_d;
   logic [UUS_DW-1:0] conv_in_q, conv_in_d, conv_out_q, conv_out_d;
   logic neg_q, neg_d, done_q, done_d, err_q, err_d, done_p_q, done_p_d;
   logic div_start, div_done;
   logic [MW-1:0] dividend, div_quo;

   // Conversion sequencer; a start while busy is ignored
   always_comb begin
      logic [UUS_DW-1:0] mag;
      mag = conv_in_q[UUS_DW-1] ? -conv_in_q : conv_in_q;
      dividend = MW'(MW'(mag) * MW'(num));
      state_d = state_q;
      kind_d = kind_q;
      conv_in_d = conv_in_q;
      conv_out_d = conv_out_q;
      neg_d = neg_q;
      done_d = done_q;
      err_d = err_q;
      done_p_d = 1'b0;
      div_start = 1'b0;
      if (wr_en && widx == IDX_CONV_IN) begin
         conv_in_d = merge(conv_in_q, pwdata, pstrb);
      end
      unique case (state_q)
         S_IDLE: begin
            if (start_req) begin
               kind_d = ctrl_w.kind;
               done_d = 1'b0;
               err_d = 1'b0;
               state_d = S_LOAD;
            end
         end
         S_LOAD: begin
            neg_d = conv_in_q[UUS_DW-1];
            if (den == '0 || sel_dec.bad) begin
               err_d = 1'b1;
               done_d = 1'b1;
               done_p_d = 1'b1;
               conv_out_d = '0;
               state_d = S_IDLE;
            end else begin
               div_start = 1'b1;
               state_d = S_RUN;
            end
         end
         S_RUN: begin
            if (div_done) begin
               conv_out_d = neg_q ? -div_quo[UUS_DW-1:0] : div_quo[UUS_DW-1:0];
               done_d = 1'b1;
               done_p_d = 1'b1;
               state_d = S_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= S_IDLE;
         kind_q <= K_POS;
         conv_in_q <= '0;
         conv_out_q <= '0;
         neg_q <= 1'b0;
         done_q <= 1'b0;
         err_q <= 1'b0;
         done_p_q <= 1'b0;
      end else begin
         state_q <= state_d;
         kind_q <= kind_d;
         conv_in_q <= conv_in_d;
         conv_out_q <= conv_out_d;
         neg_q <= neg_d;
         done_q <= done_d;
         err_q <= err_d;
         done_p_q <= done_p_d;
      end
   end

   uus_div #(
      .W(MW)
   ) u_div (
      .pclk(pclk),
      .presetn(presetn),
      .start(div_start),
      .dividend(dividend),
      .divisor(MW'(den)),
      .busy(),
      .done(div_done),
      .quotient(div_quo)
   );

   logic [UUS_DW-1:0] prdata_q, prdata_d;

   // Read mux; configuration reads return the pending value software wrote
   always_comb begin
      uus_status_t st;
      uus_ctrl_t cr;
      logic [UUS_DW-1:0] rd_word;
      st = '0;
      cr = '0;
      rd_word = '0;
      st.pos_class = pos_dec.cls;
      st.velocity_mode = velocity_mode;
      st.op_enabled = op_enabled;
      st.spd_bad = spd_dec.bad;
      st.pos_bad = pos_dec.bad;
      st.err = err_q;
      st.done = done_q;
      st.busy = (state_q != S_IDLE);
      st.pending = dirty_q;
      cr.kind = kind_q;
      if (widx < CFG_N) begin
         rd_word = pend_q[widx];
      end else begin
         case (widx)
            IDX_CONV_IN: rd_word = conv_in_q;
            IDX_CONV_CTRL: rd_word = cr;
            IDX_CONV_OUT: rd_word = conv_out_q;
            IDX_STATUS: rd_word = st;
            default: rd_word = '0;
         endcase
      end
      prdata_d = (setup_ph && !pwrite) ? rd_word : prdata_q;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
      end else begin
         prdata_q <= prdata_d;
      end
   end

   // Status pins
   assign prdata = prdata_q;
   assign cfg_pending = dirty_q;
   assign conv_busy = (state_q != S_IDLE);
   assign conv_done = done_p_q;
endmodule : uus_core

// ---- core/uus_decode.sv ----
`timescale 1ns/1ns
module uus_decode (
   input wire uus_pkg::uus_unit_word_t word,
   input wire logic time_en,
   output uus_pkg::uus_dec_t dec
);
   import uus_pkg::*;

   // Power of ten by repeated multiplication, never more than six steps
   function automatic logic [UUS_DW-1:0] pow10(input logic [EXP_W-1:0] n);
      logic [UUS_DW-1:0] r;
      r = ONE;
      for (int i = 0; i < int'(EXP_MAX); i++) begin
         if (i < int'(n)) begin
            r = UUS_DW'(r * TEN);
         end
      end
      return r;
   endfunction : pow10

   // Unit class, turns per unit, power of ten and seconds per time unit
   always_comb begin
      logic signed [7:0] e;
      e = word.exp;
      dec = '0;
      dec.cls = C_BAD;
      dec.tn = ONE;
      dec.td = ONE;
      dec.pow_n = ONE;
      dec.pow_d = ONE;
      dec.secs = ONE;
      case (word.unit)
         U_DIMLESS, U_METER, U_INCH, U_FOOT: begin
            dec.cls = C_LEN; // Feed constant is in user units, so the length code only classes
            dec.gear = 1'b1;
            dec.feed = 1'b1;
         end
         U_GRAD, U_RAD, U_DEG, U_AMIN, U_ASEC, U_REV: begin
            dec.cls = C_ANGLE;
            dec.gear = 1'b1;
         end
         U_INC: dec.cls = C_ENC;
         U_STEP: dec.cls = C_STEP;
         U_POLE: dec.cls = C_POLE;
         default: dec.bad = 1'b1;
      endcase
      // Radian uses a rational approximation of one over two pi
      case (word.unit)
         U_GRAD: dec.td = UPT_GRAD;
         U_DEG: dec.td = UPT_DEG;
         U_AMIN: dec.td = UPT_AMIN;
         U_ASEC: dec.td = UPT_ASEC;
         U_RAD: begin
            dec.tn = RAD_TURN_N;
            dec.td = RAD_TURN_D;
         end
         default: dec.td = ONE;
      endcase
      if (e > EXP_MAX || e < EXP_MIN) begin
         dec.bad = 1'b1;
      end else if (e >= 0) begin
         dec.pow_n = pow10(EXP_W'(e));
      end else begin
         dec.pow_d = pow10(EXP_W'(-e));
      end
      if (time_en) begin
         case (word.time_unit)
            T_SEC: dec.secs = ONE;
            T_MIN: dec.secs = SEC_MIN;
            T_HOUR: dec.secs = SEC_HOUR;
            T_DAY: dec.secs = SEC_DAY;
            T_YEAR: dec.secs = SEC_YEAR;
            default: dec.bad = 1'b1;
         endcase
      end
   end
endmodule : uus_decode

// ---- core/uus_div.sv ----
`timescale 1ns/1ns
module uus_div #(
   parameter int W = 160
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic [W-1:0] dividend,
   input wire logic [W-1:0] divisor,
   output logic busy,
   output logic done,
   output logic [W-1:0] quotient
);
   import uus_pkg::*;

   localparam int CW = $clog2(W + 1);

   logic [W-1:0] rem_q, rem_d, quo_q, quo_d, dsr_q, dsr_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic busy_q, busy_d, done_q, done_d;

   // Restoring division, one quotient bit per clock; divisor latched so config may move
   always_comb begin
      logic [W:0] trial;
      trial = {rem_q, quo_q[W-1]};
      rem_d = rem_q;
      quo_d = quo_q;
      dsr_d = dsr_q;
      cnt_d = cnt_q;
      busy_d = busy_q;
      done_d = 1'b0;
      if (start && !busy_q) begin
         rem_d = '0;
         quo_d = dividend;
         dsr_d = divisor;
         cnt_d = CW'(W);
         busy_d = 1'b1;
      end else if (busy_q) begin
         quo_d = {quo_q[W-2:0], 1'b0};
         if (trial >= {1'b0, dsr_q}) begin
            rem_d = W'(trial - {1'b0, dsr_q});
            quo_d[0] = 1'b1;
         end else begin
            rem_d = trial[W-1:0];
         end
         cnt_d = cnt_q - 1'b1;
         if (cnt_q == CW'(1)) begin
            busy_d = 1'b0;
            done_d = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rem_q <= '0;
         quo_q <= '0;
         dsr_q <= '0;
         cnt_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         rem_q <= rem_d;
         quo_q <= quo_d;
         dsr_q <= dsr_d;
         cnt_q <= cnt_d;
         busy_q <= busy_d;
         done_q <= done_d;
      end
   end

   assign busy = busy_q;
   assign done = done_q;
   assign quotient = quo_q;
endmodule : uus_div

// ---- shared/uus_pkg.sv ----
package uus_pkg;
   localparam int UUS_DW = 32;
   localparam int UUS_AW = 8;
   localparam int UUS_SW = UUS_DW / 8;
   localparam int BYTE_W = 8;
   localparam int ADDR_LSB = 2;
   // Register indices; the byte address is four times the index
   localparam int IDX_POS_UNIT = 0;
   localparam int IDX_SPD_UNIT = 1;
   localparam int IDX_ENC_INC = 2;
   localparam int IDX_MOTOR_REV = 3;
   localparam int IDX_GEAR_MOTOR = 4;
   localparam int IDX_GEAR_SHAFT = 5;
   localparam int IDX_FEED = 6;
   localparam int IDX_FEED_SHAFT = 7;
   localparam int IDX_VEL_NUM = 8;
   localparam int IDX_VEL_DEN = 9;
   localparam int IDX_ACC_NUM = 10;
   localparam int IDX_ACC_DEN = 11;
   localparam int IDX_JERK_NUM = 12;
   localparam int IDX_JERK_DEN = 13;
   localparam int IDX_VMS_NUM = 14;
   localparam int IDX_VMS_DEN = 15;
   localparam int IDX_POLE_PAIRS = 16;
   localparam int IDX_MOTOR_CFG = 17;
   localparam int CFG_N = 18;
   localparam int IDX_CONV_IN = 18;
   localparam int IDX_CONV_CTRL = 19;
   localparam int IDX_CONV_OUT = 20;
   localparam int IDX_STATUS = 21;
   localparam int IDX_LAST = 21;
   // Reset values and writable bits
   localparam logic [UUS_DW-1:0] POS_UNIT_RST = 32'hFF41_0000;
   localparam logic [UUS_DW-1:0] SPD_UNIT_RST = 32'h00B4_4700;
   localparam logic [UUS_DW-1:0] VEL_MODE_WORD = 32'h00B4_4700;
   localparam logic [UUS_DW-1:0] ONE = 32'h0000_0001;
   localparam logic [UUS_DW-1:0] TEN = 32'h0000_000A;
   localparam logic [UUS_DW-1:0] ZERO = 32'h0000_0000;
   localparam logic [UUS_DW-1:0] POS_WORD_MASK = 32'hFFFF_0000;
   localparam logic [UUS_DW-1:0] SPD_WORD_MASK = 32'hFFFF_FF00;
   localparam logic [UUS_DW-1:0] MCFG_MASK = 32'h0000_0003;
   localparam logic [UUS_DW-1:0] ALL_MASK = 32'hFFFF_FFFF;
   // Unit codes
   localparam logic [7:0] U_DIMLESS = 8'h00;
   localparam logic [7:0] U_METER = 8'h01;
   localparam logic [7:0] U_INCH = 8'hC1;
   localparam logic [7:0] U_FOOT = 8'hC2;
   localparam logic [7:0] U_GRAD = 8'h40;
   localparam logic [7:0] U_RAD = 8'h10;
   localparam logic [7:0] U_DEG = 8'h41;
   localparam logic [7:0] U_AMIN = 8'h42;
   localparam logic [7:0] U_ASEC = 8'h43;
   localparam logic [7:0] U_REV = 8'hB4;
   localparam logic [7:0] U_INC = 8'hB5;
   localparam logic [7:0] U_STEP = 8'hAC;
   localparam logic [7:0] U_POLE = 8'hC0;
   localparam logic [7:0] T_SEC = 8'h03;
   localparam logic [7:0] T_MIN = 8'h47;
   localparam logic [7:0] T_HOUR = 8'h48;
   localparam logic [7:0] T_DAY = 8'h49;
   localparam logic [7:0] T_YEAR = 8'h4A;
   localparam logic signed [7:0] EXP_MAX = 8'sh06;
   localparam logic signed [7:0] EXP_MIN = 8'shFA;
   localparam int EXP_W = 3;
   // Units per turn, seconds per time unit, increments per pole pair
   localparam logic [UUS_DW-1:0] UPT_GRAD = 32'h0000_0190;
   localparam logic [UUS_DW-1:0] UPT_DEG = 32'h0000_0168;
   localparam logic [UUS_DW-1:0] UPT_AMIN = 32'h0000_5460;
   localparam logic [UUS_DW-1:0] UPT_ASEC = 32'h0013_C680;
   localparam logic [UUS_DW-1:0] RAD_TURN_N = 32'h0000_0071;
   localparam logic [UUS_DW-1:0] RAD_TURN_D = 32'h0000_02C6;
   localparam logic [UUS_DW-1:0] SEC_MIN = 32'h0000_003C;
   localparam logic [UUS_DW-1:0] SEC_HOUR = 32'h0000_0E10;
   localparam logic [UUS_DW-1:0] SEC_DAY = 32'h0001_5180;
   localparam logic [UUS_DW-1:0] SEC_YEAR = 32'h01E1_87E0;
   localparam logic [UUS_DW-1:0] OL_INC_PER_POLE = 32'h0001_0000;
   localparam logic [UUS_DW-1:0] STEPS_2PH = 32'h0000_0004;
   localparam logic [UUS_DW-1:0] STEPS_3PH = 32'h0000_0006;

   typedef enum logic [2:0] {C_LEN, C_ANGLE, C_ENC, C_STEP, C_POLE, C_BAD} uus_class_t;
   typedef enum logic [1:0] {K_POS, K_SPD, K_ACC, K_JERK} uus_kind_t;

   typedef struct packed {
      logic [7:0] exp;
      logic [7:0] unit;
      logic [7:0] time_unit;
      logic [7:0] rsvd;
   } uus_unit_word_t;

   typedef struct packed {
      uus_class_t cls;
      logic gear;
      logic feed;
      logic bad;
      logic [UUS_DW-1:0] tn;
      logic [UUS_DW-1:0] td;
      logic [UUS_DW-1:0] pow_n;
      logic [UUS_DW-1:0] pow_d;
      logic [UUS_DW-1:0] secs;
   } uus_dec_t;

   typedef struct packed {
      logic [28:0] rsvd;
      logic start;
      uus_kind_t kind;
   } uus_ctrl_t;

   typedef struct packed {
      logic [29:0] rsvd;
      logic three_phase;
      logic open_loop;
   } uus_mcfg_t;

   typedef struct packed {
      logic [20:0] rsvd;
      uus_class_t pos_class;
      logic velocity_mode;
      logic op_enabled;
      logic spd_bad;
      logic pos_bad;
      logic err;
      logic done;
      logic busy;
      logic pending;
   } uus_status_t;
endpackage : uus_pkg

// ---- tb/user_unit_scaling_test.sv ----
`timescale 1ns/1ns
module user_unit_scaling_test;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic op_enabled = 1'b0;
   logic velocity_mode = 1'b0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata, r;
   logic pready, pslverr, e, cfg_pending, conv_busy, conv_done;
   int miscompares = 0;
   int num_checks = 0;
   int cyc = 0;
   // 4 ns period
   always #2 pclk = ~pclk;
   uus_core DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .op_enabled(op_enabled), .velocity_mode(velocity_mode),
      .cfg_pending(cfg_pending), .conv_busy(conv_busy), .conv_done(conv_done)
   );
   // Compare and tally
   task automatic chk(input string n, input logic [31:0] x, g);
      num_checks++;
      if (g !== x) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   // Setup, then access held until pready is sampled high
   task automatic apb(input logic [7:0] a, input logic [31:0] d, input logic w = 1'b1);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Done is a one-cycle pulse, so poll every cycle
   task automatic conv(input logic [1:0] k, input logic [31:0] v, x);
      apb(8'h48, v);
      apb(8'h4C, {29'h1, k});
      @(negedge pclk);
      chk("busy", 32'h1, {31'h0, conv_busy});
      for (int i = 0; i < 200 && conv_done !== 1'b1; i++) @(negedge pclk);
      chk("done", 32'h1, {31'h0, conv_done});
      apb(8'h50, 32'h0, 1'b0);
      chk("result", x, r);
   endtask : conv
   // Reset values, reserved bits, unmapped read
   task automatic t_regs;
      apb(8'h00, 32'h0, 1'b0);
      chk("pos word", 32'hFF410000, r);
      apb(8'h04, 32'h0, 1'b0);
      chk("speed word", 32'hB44700, r);
      apb(8'h00, 32'hFFFFFFFF);
      apb(8'h00, 32'h0, 1'b0);
      chk("pos rsvd", 32'hFFFF0000, r);
      apb(8'h04, 32'hFFFFFFFF);
      apb(8'h04, 32'h0, 1'b0);
      chk("speed rsvd", 32'hFFFFFF00, r);
      apb(8'hFC, 32'h0, 1'b0);
      chk("unmapped", 32'h1, {r[30:0], e});
      $display("end regs");
   endtask : t_regs
   // Position word, motor cfg, input, increments
   task automatic t_pos;
      logic [31:0] t [8][4] = '{'{32'hFF410000, 32'h0, 32'hE10, 32'h1C20},
         '{32'h10000, 32'h0, 32'hA, 32'h4650}, '{32'hB50000, 32'h0, 32'h7B, 32'h7B},
         '{32'hAC0000, 32'h0, 32'hC8, 32'hE10}, '{32'hAC0000, 32'h2, 32'h12C, 32'hE10},
         '{32'hC00000, 32'h0, 32'h32, 32'hE10}, '{32'hB40000, 32'h1, 32'h1, 32'h640000},
         '{32'h400000, 32'h0, 32'h190, 32'h1C20}};
      apb(8'h08, 32'hE10);
      apb(8'h10, 32'h2);
      apb(8'h18, 32'h4);
      apb(8'h40, 32'h32);
      foreach (t[i]) begin
         apb(8'h00, t[i][0]);
         apb(8'h44, t[i][1]);
         conv(2'h0, t[i][2], t[i][3]);
      end
      $display("end pos");
   endtask : t_pos
   // Speed word, kind, input, increments per second power
   task automatic t_speed;
      logic [31:0] t [4][4] = '{'{32'hB44700, 32'h1, 32'h3C, 32'h1C20},
         '{32'hB44A00, 32'h1, 32'h1E187E0, 32'h1C20},
         '{32'hB44700, 32'h2, 32'h3C, 32'h3840}, '{32'hB44700, 32'h3, 32'h3C, 32'hA8C0}};
      apb(8'h28, 32'h2);
      apb(8'h30, 32'h3);
      foreach (t[i]) begin
         apb(8'h04, t[i][0]);
         conv(t[i][1][1:0], t[i][2], t[i][3]);
      end
      apb(8'h24, 32'h3);
      conv(2'h1, 32'h3C, 32'h960);
      velocity_mode <= 1'b1;
      apb(8'h04, 32'hB40300);
      conv(2'h1, 32'h3C, 32'h1C20);
      velocity_mode <= 1'b0;
      $display("end speed");
   endtask : t_speed
   // Parked change must not reach the conversion until enable drops
   task automatic t_defer;
      op_enabled <= 1'b1;
      apb(8'h08, 32'h1C20);
      repeat (20) @(negedge pclk);
      chk("parked", 32'h1, {31'h0, cfg_pending});
      conv(2'h0, 32'h190, 32'h1C20);
      op_enabled <= 1'b0;
      repeat (2) @(negedge pclk);
      chk("applied", 32'h0, {31'h0, cfg_pending});
      conv(2'h0, 32'h190, 32'h3840);
      apb(8'h00, 32'h7410000);
      conv(2'h0, 32'h1, 32'h0);
      apb(8'h54, 32'h0, 1'b0);
      chk("error flag", 32'h1, {31'h0, r[3]});
      $display("end defer");
   endtask : t_defer
   // Verdict
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize
   // Main sequence
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_pos();
      t_speed();
      t_defer();
      summarize();
   end
   // Hang guard
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         summarize();
      end
   end
endmodule : user_unit_scaling_test

// ---- tb/uus_monitor.sv ----
`timescale 1ns/1ns
module uus_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pslverr,
   input wire logic op_enabled,
   input wire logic cfg_pending,
   input wire logic conv_busy,
   input wire logic conv_done
);
   import uus_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Start needs strobe byte 0, since bit 2 lives there
   wire acc = psel && penable;
   wire cfg_wr = acc && pwrite && paddr[7:2] < CFG_N;
   wire go = acc && pwrite && paddr[7:2] == IDX_CONV_CTRL && pstrb[0] && pwdata[2];
   a_pend_held: assert property (op_enabled && cfg_pending |=> cfg_pending)
      else $error("pending dropped");
   a_pend_set: assert property (cfg_wr |=> cfg_pending)
      else $error("write not pending");
   a_pend_apply: assert property (cfg_pending && !op_enabled && !cfg_wr |=> !cfg_pending)
      else $error("not applied");
   a_conv_start: assert property (go && !conv_busy |=> conv_busy)
      else $error("start lost");
   a_conv_bound: assert property ($rose(conv_busy) |-> ##[1:162] conv_done)
      else $error("conversion too long");
   a_done_pulse: assert property (conv_done |=> !conv_done)
      else $error("done too long");
   a_done_idle: assert property (conv_done |-> !conv_busy)
      else $error("done while busy");
   a_err_map: assert property (pslverr == (acc && paddr[7:2] > IDX_LAST))
      else $error("bus error wrong");
   c_conv: cover property ($rose(conv_busy));
   c_park: cover property (op_enabled && cfg_pending);
   c_unmap: cover property (pslverr);
endmodule : uus_monitor
bind uus_core uus_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .pslverr(pslverr), .op_enabled(op_enabled), .cfg_pending(cfg_pending),
   .conv_busy(conv_busy), .conv_done(conv_done));
